// ### common/pmsc_consts.vh
// constants for the power monitor and sleep control block
`ifndef PMSC_CONSTS_VH
`define PMSC_CONSTS_VH
// apb byte offsets
`define PMSC_ADDR_PWRCTL   8'h00
`define PMSC_ADDR_AUXCTL   8'h04
`define PMSC_ADDR_CONFIG   8'h08
`define PMSC_ADDR_IRQEN    8'h0C
`define PMSC_ADDR_STATUS   8'h10
// power_control_reg fields
`define PMSC_PC_IDLE       0
`define PMSC_PC_PDOWN      1
`define PMSC_PC_POF        4
`define PMSC_PC_BOF        5
`define PMSC_PC_RST_POR    8'h30
`define PMSC_PC_RST_BOR    8'h20
`define PMSC_PC_RST_OTHER  8'h00
// aux_control_one fields
`define PMSC_AUX_BOI       5
`define PMSC_AUX_BOD       6
// user_config_byte_one fields (own layout)
`define PMSC_CFG_BOV       0
`define PMSC_CFG_WDRST     1
`define PMSC_CFG_XTAL      2
`define PMSC_CFG_RESET     8'h01
// irq_enable_reg_zero fields (own layout)
`define PMSC_IE_GLOBAL     7
`define PMSC_IE_BROWN      5
// oscillator stability counts, cpu clocks
`define PMSC_STAB_XTAL     11'd1024
`define PMSC_STAB_RC       11'd256
`endif

// ### verilog/pmsc_sync.v
// two-flop synchroniser for one level
`timescale 1ns/1ps
module pmsc_sync (
  input  wire clock,  // logic clock
  input  wire rst_b,  // async reset, active low
  input  wire din,    // asynchronous level
  output wire dout    // synchronised level
);
  reg metaQ;
  reg syncQ;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      metaQ <= 1'b0;
      syncQ <= 1'b0;
    end else begin
      metaQ <= din;
      syncQ <= metaQ;
    end
  end
  assign dout = syncQ;
endmodule

// ### verilog/pmsc_stab_cnt.v
// oscillator stability counter run after power-down wake
`timescale 1ns/1ps
`include "pmsc_consts.vh"
module pmsc_stab_cnt (
  input  wire clock,  // logic clock
  input  wire rst_b,  // async reset, active low
  input  wire start,  // one-cycle start pulse
  input  wire xtal,   // crystal oscillator mode
  output reg  done,   // one-cycle pulse at end of count
  output wire busy    // count in progress
);
  reg [10:0] count_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 11'h000;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_q <= xtal ? `PMSC_STAB_XTAL : `PMSC_STAB_RC;
      end else if (count_q != 11'h000) begin
        count_q <= count_q - 11'h001;
        if (count_q == 11'h001) begin
          done <= 1'b1;
        end
      end
    end
  end
  assign busy = (count_q != 11'h000);
endmodule

// ### verilog/pmsc_top.v
// power monitor, reset causes and idle/power-down sequencing
// Notes on behaviour
// - brownout resets cpu by default; interrupt select makes it an irq
// - level select 1 picks low threshold, 0 picks high threshold
// - in reset mode cpu reset holds while brownout reports low
// - in irq mode one request per falling crossing, none repeated
// - brownout irq serviced only with global and brownout enables
// - any brownout sets cause flag until software clears it
// - disable bit turns detector off: no reset, no interrupt
// - power-up sets power-on cause flag until software clears it
// - sleep request enters idle; enabled irq or reset ends it
// - power-down request enters power-down and stops oscillator
// - power-down ends on reset, qualified higher-priority wake irq or enabled brownout irq
// - watchdog overflow may reset cpu during power-down
// - brownout reset forces reset at once, also in power-down
// - brownout irq, when enabled, wakes from power-down
// - wake restarts oscillator; irq wake waits 1024 or 256 clocks, reset wake does not
// - watchdog reset wakes if select set; irq if clear and enabled
// - brownout reset wakes only with disable and select clear
// - adc wakes only on rc clock, enabled, irq enabled
// - ext, keypad, comparator wake only if enabled and irq enabled
// - brownout, watchdog and comparators run in power-down
// - power-down bit 1, sleep bit 0, cleared when mode ends
// - control reg resets 30h power-on; 20h brownout, 00h others, or-ed with held cause flags
`timescale 1ns/1ps
`include "pmsc_consts.vh"
module pmsc_top (
  input  wire        clock,           // 200 MHz logic clock
  input  wire        rst_b,           // async reset, active low
  input  wire        psel,            // apb select
  input  wire        penable,         // apb enable
  input  wire        pwrite,          // apb direction
  input  wire [7:0]  paddr,           // apb byte address
  input  wire [31:0] pwdata,          // apb write data
  output reg  [31:0] prdata,          // apb read data
  output reg         pready,          // apb ready
  output reg         pslverr,         // apb error
  input  wire        brownoutLow,     // async comparator, supply low
  input  wire        powerOnDet,      // async power-on detector
  input  wire        extResetReq,     // external reset request, level
  input  wire        watchdogOvf,     // watchdog overflow pulse
  input  wire        wakeIrqPend,     // pending irqs of ext/kbd/cmp/adc/wdt
  input  wire        wakeFeatureOk,   // those sources enabled and set up
  input  wire        wakeIrqEnable,   // their irq enables
  input  wire        wakePrioHigher,  // above in-service priority
  input  wire        adcRcClock,      // adc_rc_clock_select
  input  wire        adcWakeReq,      // adc wake request
  output reg         cpuResetReq,     // processor reset
  output reg         cpuClockEnable,  // cpu clock gate
  output reg         oscEnable,       // main oscillator run
  output reg         brownoutIrq,     // brownout irq to controller
  output reg         brownoutLevelHi, // 1 selects higher threshold
  output reg         brownoutEnable   // detector power
);
  localparam ST_RUN   = 2'd0;
  localparam ST_IDLE  = 2'd1;
  localparam ST_PDOWN = 2'd2;
  localparam ST_STAB  = 2'd3;

  reg  [1:0] state_q;
  reg  [7:0] pwrCtl_q;
  reg  [7:0] auxCtl_q;
  reg  [7:0] config_q;
  reg  [7:0] irqEn_q;
  reg        borPrev_q;
  reg        porSeen_q;
  reg        bojReset_q;
  reg        loadCause_q;
  wire       borSync;
  wire       porSync;
  wire       stabDone;
  wire       stabBusy;

  function [7:0] field8;
    input [31:0] d;
    begin
      field8 = d[7:0];
    end
  endfunction

  pmsc_sync uBorSync (
    .clock (clock),
    .rst_b (rst_b),
    .din   (brownoutLow),
    .dout  (borSync)
  );
  pmsc_sync uPorSync (
    .clock (clock),
    .rst_b (rst_b),
    .din   (powerOnDet),
    .dout  (porSync)
  );

  wire bodOff   = auxCtl_q[`PMSC_AUX_BOD];
  wire boiSel   = auxCtl_q[`PMSC_AUX_BOI];
  wire borActive = borSync & ~bodOff;
  wire borFall  = borActive & ~borPrev_q;
  wire borResetMode = borActive & ~boiSel;
  wire boIrqEvt = borFall & boiSel;
  wire boIrqOk  = irqEn_q[`PMSC_IE_GLOBAL] & irqEn_q[`PMSC_IE_BROWN];
  wire wdResetSel = config_q[`PMSC_CFG_WDRST];
  wire wdReset  = watchdogOvf & wdResetSel;
  wire anyReset = borResetMode | porSync | extResetReq | wdReset;
  wire srcWake  = wakeIrqPend & wakeFeatureOk & wakeIrqEnable
                  & wakePrioHigher;
  // adc shares the feature, enable and priority qualifiers of other sources
  wire adcWake  = adcWakeReq & adcRcClock & wakeFeatureOk & wakeIrqEnable
                  & wakePrioHigher;
  wire boWake   = boIrqEvt & boIrqOk;
  wire pdWake   = srcWake | adcWake | boWake;
  wire idleWake = (wakeIrqPend & wakeIrqEnable) | boWake;
  wire wrEn     = psel & penable & pwrite & pready;
  wire wrPc     = wrEn & (paddr == `PMSC_ADDR_PWRCTL);

  // detector state, edge history and reset-cause latches
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      borPrev_q   <= 1'b0;
      porSeen_q   <= 1'b0;
      bojReset_q  <= 1'b0;
      loadCause_q <= 1'b0;
    end else begin
      borPrev_q <= borActive;
      if (anyReset) begin
        porSeen_q   <= porSeen_q | porSync;
        bojReset_q  <= bojReset_q | borResetMode;
        loadCause_q <= 1'b1;
      end else begin
        porSeen_q   <= 1'b0;
        bojReset_q  <= 1'b0;
        loadCause_q <= 1'b0;
      end
    end
  end

  // power control register and mode sequencing
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwrCtl_q <= `PMSC_PC_RST_POR;
      state_q  <= ST_RUN;
    end else if (anyReset) begin
      state_q <= ST_RUN;
      pwrCtl_q[`PMSC_PC_IDLE]  <= 1'b0;
      pwrCtl_q[`PMSC_PC_PDOWN] <= 1'b0;
    end else begin
      if (loadCause_q) begin
        // reset just released: load value by cause, keep sticky flags
        if (porSeen_q) begin
          pwrCtl_q <= `PMSC_PC_RST_POR;
        end else if (bojReset_q) begin
          pwrCtl_q <= `PMSC_PC_RST_BOR | (pwrCtl_q & 8'h10);
        end else begin
          pwrCtl_q <= `PMSC_PC_RST_OTHER | (pwrCtl_q & 8'h30);
        end
      end else if (wrPc) begin
        pwrCtl_q <= field8(pwdata);
        if (borFall) begin
          pwrCtl_q[`PMSC_PC_BOF] <= 1'b1;
        end
      end else if (borFall) begin
        pwrCtl_q[`PMSC_PC_BOF] <= 1'b1;
      end
      case (state_q)
        ST_RUN: begin
          if (pwrCtl_q[`PMSC_PC_PDOWN]) begin
            state_q <= ST_PDOWN;
          end else if (pwrCtl_q[`PMSC_PC_IDLE]) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (idleWake) begin
            state_q <= ST_RUN;
            pwrCtl_q[`PMSC_PC_IDLE] <= 1'b0;
          end
        end
        ST_PDOWN: begin
          if (pdWake) begin
            state_q <= ST_STAB;
          end
        end
        ST_STAB: begin
          if (stabDone) begin
            state_q <= ST_RUN;
            pwrCtl_q[`PMSC_PC_PDOWN] <= 1'b0;
            pwrCtl_q[`PMSC_PC_IDLE]  <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  pmsc_stab_cnt uStab (
    .clock (clock),
    .rst_b (rst_b),
    .start (state_q == ST_PDOWN && pdWake && !anyReset),
    .xtal  (config_q[`PMSC_CFG_XTAL]),
    .done  (stabDone),
    .busy  (stabBusy)
  );

  // apb slave: zero wait, other registers, read mux
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      auxCtl_q <= 8'h00;
      config_q <= `PMSC_CFG_RESET;
      irqEn_q  <= 8'h00;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        case (paddr)
          `PMSC_ADDR_PWRCTL: prdata <= {24'h00_0000, pwrCtl_q};
          `PMSC_ADDR_AUXCTL: prdata <= {24'h00_0000, auxCtl_q};
          `PMSC_ADDR_CONFIG: prdata <= {24'h00_0000, config_q};
          `PMSC_ADDR_IRQEN:  prdata <= {24'h00_0000, irqEn_q};
          `PMSC_ADDR_STATUS: prdata <= {27'h000_0000, stabBusy,
                                        borSync, state_q, 1'b0};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (wrEn) begin
        case (paddr)
          `PMSC_ADDR_AUXCTL: auxCtl_q <= field8(pwdata);
          `PMSC_ADDR_CONFIG: config_q <= field8(pwdata);
          `PMSC_ADDR_IRQEN:  irqEn_q  <= field8(pwdata);
          default: begin
            auxCtl_q <= auxCtl_q;
          end
        endcase
      end
    end
  end

  // registered outputs
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cpuResetReq     <= 1'b1;
      cpuClockEnable  <= 1'b0;
      oscEnable       <= 1'b1;
      brownoutIrq     <= 1'b0;
      brownoutLevelHi <= 1'b0;
      brownoutEnable  <= 1'b1;
    end else begin
      cpuResetReq     <= anyReset;
      cpuClockEnable  <= ~anyReset & (state_q == ST_RUN);
      oscEnable       <= (state_q != ST_PDOWN) | pdWake | anyReset;
      brownoutIrq     <= boIrqEvt & boIrqOk;
      brownoutLevelHi <= ~config_q[`PMSC_CFG_BOV];
      brownoutEnable  <= ~bodOff;
    end
  end
endmodule

// ### tb/pmsc_chk.sv
// port assertions for the power monitor block
`timescale 1ns/1ps
module pmsc_chk (
  input wire clock,          // clock
  input wire rst_b,          // reset
  input wire psel,           // apb select
  input wire penable,        // apb enable
  input wire pready,         // apb ready
  input wire brownoutLow,    // supply low
  input wire powerOnDet,     // power-on
  input wire extResetReq,    // ext reset
  input wire cpuResetReq,    // cpu reset
  input wire cpuClockEnable, // cpu clock
  input wire oscEnable,      // oscillator
  input wire brownoutIrq,    // brownout irq
  input wire brownoutEnable  // detector on
);
  logic [10:0] stab_q;
  logic        woke_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // cycles since the oscillator came back; woke_q marks a power-down exit
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stab_q <= 11'h000;
      woke_q <= 1'b0;
    end else begin
      if (!oscEnable) stab_q <= 11'h000;
      else if (stab_q != 11'h7ff) stab_q <= stab_q + 11'h001;
      if (cpuResetReq || cpuClockEnable) woke_q <= 1'b0;
      else if (!oscEnable) woke_q <= 1'b1;
    end
  end
  sequence sSetup;
    psel && !penable;
  endsequence
  sequence sAccess;
    psel && penable && pready;
  endsequence
  AST_APB_READY: assert property (sSetup |=> sAccess)
    else $error("apb access not answered in one cycle");
  AST_BOD_QUIET: assert property (
    !brownoutEnable && !$past(brownoutEnable, 4) |-> !brownoutIrq)
    else $error("brownout irq while detector off");
  AST_IRQ_ONCE: assert property (
    brownoutIrq |=> !brownoutIrq [*8])
    else $error("brownout irq repeated");
  AST_IRQ_CAUSE: assert property (
    brownoutIrq |-> $past(brownoutLow, 2))
    else $error("brownout irq without low supply");
  AST_OSC_CPU: assert property (!oscEnable |-> !cpuClockEnable)
    else $error("cpu clock runs with oscillator stopped");
  AST_POR: assert property (
    $rose(powerOnDet) |-> ##[1:5] cpuResetReq)
    else $error("power-on gave no cpu reset");
  AST_EXT: assert property (
    $rose(extResetReq) |-> ##[1:3] cpuResetReq)
    else $error("external reset not passed on");
  AST_STAB: assert property (
    $rose(cpuClockEnable) && woke_q |-> stab_q >= 11'h0fa)
    else $error("cpu restarted before oscillator settled");
endmodule
bind pmsc_top pmsc_chk pmsc_chk_inst (.clock(clock), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pready(pready),
  .brownoutLow(brownoutLow), .powerOnDet(powerOnDet),
  .extResetReq(extResetReq), .cpuResetReq(cpuResetReq),
  .cpuClockEnable(cpuClockEnable), .oscEnable(oscEnable),
  .brownoutIrq(brownoutIrq), .brownoutEnable(brownoutEnable));

// ### tb/pmsc_partner.sv
// cpu side, irq controller and wake sources around the block
`timescale 1ns/1ps
module pmsc_partner (
  input  wire        clock,          // clock
  input  wire        brownoutIrq,    // irq request in
  input  wire        cpuClockEnable, // cpu running
  output logic [6:0] src             // wake source levels
);
  int irqSeen = 0;
  initial src = 7'h00;
  always @(posedge clock) begin
    if (brownoutIrq === 1'b1) irqSeen <= irqSeen + 1;
  end
  // source drops its request once the cpu runs or after n cycles, as if serviced
  task automatic wake(input logic [6:0] v, input int n);
    int i;
    @(posedge clock);
    src <= v;
    for (i = 0; i < n && cpuClockEnable !== 1'b1; i++) @(posedge clock);
    src <= 7'h00;
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the power monitor block
`timescale 1ns/1ps
`include "pmsc_consts.vh"
module tb_top;
  localparam logic [7:0] PC = `PMSC_ADDR_PWRCTL;
  localparam logic [7:0] AX = `PMSC_ADDR_AUXCTL;
  localparam logic [7:0] CF = `PMSC_ADDR_CONFIG;
  logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, slv, q, bLow = 0, por = 0, extR = 0;
  logic cpuRst, cpuClk, osc, bIrq, lvlHi, bEn;
  logic [6:0] src, v;
  int n_fail = 0, checks = 0, seed = 76, n, b, s, expPc;
  pmsc_top pmsc_top_inst (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownoutLow(bLow), .powerOnDet(por), .extResetReq(extR),
    .watchdogOvf(src[6]), .wakeIrqPend(src[0]), .wakeFeatureOk(src[1]),
    .wakeIrqEnable(src[2]), .wakePrioHigher(src[3]), .adcRcClock(src[4]),
    .adcWakeReq(src[5]), .cpuResetReq(cpuRst), .cpuClockEnable(cpuClk),
    .oscEnable(osc), .brownoutIrq(bIrq), .brownoutLevelHi(lvlHi),
    .brownoutEnable(bEn));
  pmsc_partner pmsc_partner_inst (.clock(clock), .brownoutIrq(bIrq),
    .cpuClockEnable(cpuClk), .src(src));
  initial forever #2.5 clock = ~clock;
  task automatic chk(input string t, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", t, e, g);
    end
  endtask
  task automatic ap(input logic w, input logic [7:0] a, d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    ap(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input int e);
    ap(1'b0, a, 8'h00);
    chk("register", e, rd);
  endtask
  task automatic run;
    n = 0;
    while (cpuClk !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic go(input logic [6:0] w, input int m);
    fork
      pmsc_partner_inst.wake(w, m);
    join_none
  endtask
  task automatic kick;
    extR <= 1'b1;
    repeat (4) @(posedge clock);
    extR <= 1'b0;
    run;
  endtask
  task automatic sleep(input logic [7:0] m);
    wr(PC, m);
    repeat (3) @(posedge clock);
    chk("cpuClk", 0, cpuClk);
    chk("osc", m[0], osc);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    results;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    expPc = `PMSC_PC_RST_POR;
    rdc(PC, expPc);
    rdc(CF, `PMSC_CFG_RESET);
    wr(8'h14, 8'hff);
    chk("slverr", 1, slv);
    for (b = 0; b < 2; b++) begin
      wr(CF, b);
      repeat (3) @(posedge clock);
      chk("levelHi", !b, lvlHi);
    end
    wr(PC, 8'h00);
    wr(AX, 8'h20);
    wr(`PMSC_ADDR_IRQEN, 8'ha0);
    bLow <= 1'b1;
    repeat (30) @(posedge clock);
    chk("irqs", 1, pmsc_partner_inst.irqSeen);
    chk("cpuRst", 0, cpuRst);
    bLow <= 1'b0;
    expPc = 1 << `PMSC_PC_BOF;
    rdc(PC, expPc);
    $display("irq mode done");
    wr(AX, 8'h00);
    sleep(8'h02);
    bLow <= 1'b1;
    repeat (20) @(posedge clock);
    chk("cpuRst", 1, cpuRst);
    bLow <= 1'b0;
    run;
    chk("cpuRun", 1, cpuClk);
    rdc(PC, `PMSC_PC_RST_BOR);
    wr(AX, 8'h40);
    repeat (3) @(posedge clock);
    chk("detOn", 0, bEn);
    bLow <= 1'b1;
    repeat (20) @(posedge clock);
    chk("cpuRst", 0, cpuRst);
    bLow <= 1'b0;
    wr(AX, 8'h00);
    $display("reset mode done");
    sleep(8'h01);
    go(7'h05, 20);
    run;
    chk("idleWake", 1, n < 20);
    rdc(PC, 0);
    for (b = 0; b < 2; b++) begin
      wr(CF, 8'h01 + 8'h04 * b);
      sleep(8'h02);
      go(7'h0f, 2000);
      run;
      s = b ? `PMSC_STAB_XTAL : `PMSC_STAB_RC;
      chk("stabWindow", 1, n >= s && n <= s + 12);
      rdc(PC, 0);
    end
    wr(CF, 8'h01);
    for (b = 0; b < 10; b++) begin
      v = $random(seed);
      v[6] = 1'b0;
      if (b[0]) v[3:1] = 3'b111;
      q = v[3] & v[2] & v[1] & (v[0] | v[5] & v[4]);
      sleep(8'h02);
      go(v, 40);
      repeat (300) @(posedge clock);
      chk("woke", q, cpuClk);
      if (cpuClk !== 1'b1) kick;
    end
    for (b = 0; b < 2; b++) begin
      wr(CF, 8'h01 + 8'h02 * b);
      sleep(8'h02);
      go(7'h40, 2);
      n = 0;
      while (cpuRst !== 1'b1 && n < 20) begin
        @(posedge clock);
        n++;
      end
      chk("wdReset", b, cpuRst);
      kick;
    end
    $display("wake tests done");
    por <= 1'b1;
    repeat (4) @(posedge clock);
    por <= 1'b0;
    run;
    rdc(PC, `PMSC_PC_RST_POR);
    results;
  end
endmodule
